// file: spi_ctl.sv
// Purpose: Serial initiator/target controller with transmit and receive FIFOs
// Assumes: Configuration ports are held steady while a transfer or frame is active
// Notes: Target logic runs on the far initiator's clock; initiator logic on i_sys_clk
//
// What this block does
// - The link is chip select, serial clock, initiator-out data and target-out data.
// - A sender changes data on one clock edge and the receiver samples on the other.
// - Modes 0 and 3 capture on the rising edge and launch on falling; idle low / high.
// - Modes 1 and 2 capture on the falling edge and launch on rising; idle low / high.
// - As initiator all four modes work, as target only modes 1 and 3.
// - Separate receive and transmit FIFOs, shifting in and out at the same time.
// - A programmed bit length sets packets of 4 to 32 bits.
// - Packed mode only applies for lengths 3, 7, 15 or 31 (4, 8, 16, 32 bits).
// - Chip select is either software driven or set and cleared by hardware per packet.
// - The first and third ports have two chip select outputs.
// - The restricted port is initiator only, mode 0 only, single data rate only.
// - The restricted port has single and dual lane modes, both half duplex.
`default_nettype none
module spi_fifo
  import spi_ctl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_push,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_pop,
  output logic o_not_full,
  output logic o_not_empty,
  output logic [DATA_W-1:0] o_head
);
  logic [DATA_W-1:0] mem_reg [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_reg;
  logic [FIFO_AW-1:0] rd_reg;
  logic [FIFO_AW:0] cnt_reg;
  wire do_push = i_push & o_not_full;
  wire do_pop = i_pop & o_not_empty;
  wire [FIFO_AW-1:0] rd_next = rd_reg + FIFO_AW'(do_pop);
  wire [FIFO_AW:0] cnt_next = cnt_reg + (FIFO_AW+1)'(do_push) - (FIFO_AW+1)'(do_pop);
  wire [DATA_W-1:0] head_next = (do_push && wr_reg == rd_next) ? i_wdata : mem_reg[rd_next];

  always_ff @(posedge i_sys_clk) begin
    if (do_push) begin
      mem_reg[wr_reg] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      o_not_full <= 1'b1;
      o_not_empty <= 1'b0;
      o_head <= '0;
    end else begin
      wr_reg <= wr_reg + FIFO_AW'(do_push);
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      o_not_full <= cnt_next != (FIFO_AW+1)'(FIFO_DEPTH);
      o_not_empty <= cnt_next != '0;
      o_head <= head_next;
    end
  end
endmodule

module spi_ctl
  import spi_ctl_pkg::*;
#(
  parameter bit P_RESTRICTED = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_sck,
  input wire logic i_enable,
  input wire logic i_target_mode,
  input wire logic [1:0] i_mode,
  input wire logic [4:0] i_bit_len,
  input wire logic i_packed,
  input wire logic i_cs_sw_mode,
  input wire logic i_cs_sw_assert,
  input wire logic i_cs_sel,
  input wire logic [7:0] i_clk_div,
  input wire logic i_dual,
  input wire logic i_hd_rx,
  input wire logic [DATA_W-1:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [DATA_W-1:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic o_busy,
  output logic o_sck,
  output logic o_sck_oe,
  output logic [1:0] o_cs_n,
  output logic o_cs_oe,
  input wire logic i_cs_n,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_miso
);
  // ==========================================
  // Configuration decode
  logic tx_ne;
  logic [DATA_W-1:0] tx_head;
  logic rx_nf;
  wire [1:0] mode_eff = P_RESTRICTED ? MODE_RESTRICTED : i_mode;
  wire cpol = mode_eff[MODE_CPOL];
  wire cpha = mode_eff[MODE_CPHA];
  // target only in modes 1 and 3
  wire target_eff = !P_RESTRICTED & i_target_mode & mode_eff[MODE_CPHA];
  wire ini_on = i_enable & !target_eff;
  wire dual_eff = P_RESTRICTED & i_dual;
  wire hd_rx = P_RESTRICTED & i_hd_rx;
  wire hd_tx = P_RESTRICTED & !i_hd_rx;
  wire [4:0] len = (i_bit_len < LEN_MIN) ? LEN_MIN : i_bit_len;
  wire [5:0] nb = {1'b0, len} + 6'h01;
  wire [5:0] beats = dual_eff ? ((nb + 6'h01) >> 1) : nb;
  wire [6:0] last_edge = {beats, 1'b0} - 7'h01;
  wire [7:0] div_eff = (i_clk_div < DIV_MIN) ? DIV_MIN : i_clk_div;
  // packing only for 4, 8, 16, 32 bit packets
  wire [2:0] lg = (len == LEN_PACK4) ? 3'h2 : (len == LEN_PACK8) ? 3'h3 :
                  (len == LEN_PACK16) ? 3'h4 : 3'h5;
  wire packed_ok = i_packed & ((len == LEN_PACK4) | (len == LEN_PACK8) |
                   (len == LEN_PACK16) | (len == LEN_TOP));
  wire cs_sel = P_RESTRICTED ? 1'b0 : i_cs_sel;
  wire [1:0] cs_on = cs_sel ? CS_SEL1 : CS_SEL0;

  // ==========================================
  // Pin synchronisers
  logic miso_s1, miso_s, mosi_s1, mosi_s, csn_s1, csn_s;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      {miso_s1, miso_s, mosi_s1, mosi_s, csn_s1, csn_s} <= 6'h03;
    end else begin
      {miso_s1, mosi_s1, csn_s1} <= {i_miso, i_mosi, i_cs_n};
      {miso_s, mosi_s, csn_s} <= {miso_s1, mosi_s1, csn_s1};
    end
  end

  // ==========================================
  // Initiator engine
  eng_state_t state_reg, state_next;
  logic [7:0] div_reg, div_next;
  logic [6:0] edge_reg, edge_next;
  logic [2:0] pkt_reg, pkt_next;
  logic [31:0] word_reg, word_next, tx_sh_reg, tx_sh_next;
  logic [31:0] rx_sh_reg, rx_sh_next, acc_reg, acc_next;
  logic sck_reg, sck_next;
  logic [1:0] cs_n_reg, cs_n_next;
  logic ini_pop, ini_push;
  logic io0_reg, io1_reg, io0_oe_reg, io1_oe_reg;

  wire tick = div_reg == div_eff - 8'h01;
  wire lead = ~edge_reg[0];
  wire [7:0] offs = 8'({5'h00, pkt_reg} << lg);
  wire [2:0] pkt_top = 3'(LEN_TOP >> lg);
  wire pkt_last = !packed_ok | (pkt_reg == pkt_top);
  wire [31:0] tx_src = (pkt_reg == 3'h0) ? tx_head : word_reg;
  wire [31:0] tx_aligned = (tx_src >> offs) << (LEN_TOP - len);
  wire [31:0] rx_mask = WORD_ONES >> (LEN_TOP - len);
  wire can_start = ini_on & (hd_rx | (pkt_reg != 3'h0) | tx_ne) & (hd_tx | rx_nf);
  // sample and launch on opposite edges
  wire do_sample = lead ^ cpha;
  wire do_shift = cpha ? (lead & (edge_reg != 7'h00)) : !lead;

  always_comb begin
    state_next = state_reg;
    div_next = (state_reg == ST_IDLE || tick) ? 8'h00 : div_reg + 8'h01;
    edge_next = edge_reg;
    pkt_next = pkt_reg;
    word_next = word_reg;
    tx_sh_next = tx_sh_reg;
    rx_sh_next = rx_sh_reg;
    acc_next = acc_reg;
    sck_next = sck_reg;
    cs_n_next = cs_n_reg;
    ini_pop = 1'b0;
    ini_push = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        sck_next = cpol;
        edge_next = 7'h00;
        if (can_start) begin
          state_next = ST_LEAD;
          rx_sh_next = 32'h00000000;
          tx_sh_next = hd_rx ? 32'h00000000 : tx_aligned;
          if (pkt_reg == 3'h0 && !hd_rx) begin
            ini_pop = 1'b1;
            word_next = tx_head;
          end
          if (!i_cs_sw_mode) begin
            cs_n_next = cs_on;
          end
        end
      end
      ST_LEAD: begin
        if (tick) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          sck_next = ~sck_reg;
          edge_next = edge_reg + 7'h01;
          if (do_sample) begin
            rx_sh_next = dual_eff ? {rx_sh_reg[29:0], miso_s, mosi_s} :
                                    {rx_sh_reg[30:0], miso_s};
          end
          if (do_shift) begin
            tx_sh_next = dual_eff ? (tx_sh_reg << 2) : (tx_sh_reg << 1);
          end
          if (edge_reg == last_edge) begin
            state_next = ST_TAIL;
          end
        end
      end
      ST_TAIL: begin
        if (tick) begin
          state_next = ST_IDLE;
          pkt_next = pkt_last ? 3'h0 : pkt_reg + 3'h1;
          acc_next = ((pkt_reg == 3'h0) ? 32'h00000000 : acc_reg) |
                     ((rx_sh_reg & rx_mask) << offs);
          ini_push = pkt_last & !hd_tx;
          if (!i_cs_sw_mode) begin
            cs_n_next = CS_ALL_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (i_cs_sw_mode) begin
      cs_n_next = (ini_on & i_cs_sw_assert) ? cs_on : CS_ALL_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state_reg <= ST_IDLE;
      {div_reg, edge_reg, pkt_reg} <= 18'h00000;
      {word_reg, tx_sh_reg, rx_sh_reg, acc_reg} <= '0;
      sck_reg <= 1'b0;
      cs_n_reg <= CS_ALL_IDLE;
    end else begin
      state_reg <= state_next;
      {div_reg, edge_reg, pkt_reg} <= {div_next, edge_next, pkt_next};
      {word_reg, tx_sh_reg, rx_sh_reg, acc_reg} <=
        {word_next, tx_sh_next, rx_sh_next, acc_next};
      sck_reg <= sck_next;
      cs_n_reg <= cs_n_next;
    end
  end

  // initiator drives clock, select and data
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      {io0_reg, io1_reg, io0_oe_reg, io1_oe_reg} <= 4'h0;
      {o_sck_oe, o_cs_oe, o_busy} <= 3'h0;
    end else begin
      io0_reg <= dual_eff ? tx_sh_next[30] : tx_sh_next[31];
      io1_reg <= tx_sh_next[31];
      io0_oe_reg <= ini_on & !hd_rx;
      io1_oe_reg <= ini_on & dual_eff & hd_tx;
      o_sck_oe <= ini_on;
      o_cs_oe <= ini_on;
      o_busy <= (state_next != ST_IDLE) | (target_eff & !csn_s);
    end
  end

  assign o_sck = sck_reg;
  assign o_cs_n = cs_n_reg;
  assign o_mosi = io0_reg;
  assign o_mosi_oe = io0_oe_reg;

  // ==========================================
  // Target link domain
  logic [31:0] tgt_word_reg, lk_tx_sh, lk_rx_sh, lk_rx_word;
  logic [4:0] lk_lcnt, lk_tcnt;
  logic lk_out_reg, lk_oe_reg, lk_ack_tgl, lk_done_tgl;
  wire lk_clk = i_link_sck ^ cpol;
  wire [31:0] tgt_aligned = tgt_word_reg << (LEN_TOP - len);
  wire [31:0] lk_rx_next = {lk_rx_sh[30:0], i_mosi};

  // select high clears and silences target
  always_ff @(posedge lk_clk or posedge i_cs_n) begin
    if (i_cs_n) begin
      lk_lcnt <= 5'h00;
      lk_tx_sh <= 32'h00000000;
      lk_out_reg <= 1'b0;
      lk_oe_reg <= 1'b0;
    end else begin
      lk_oe_reg <= target_eff & i_enable;
      lk_lcnt <= (lk_lcnt == len) ? 5'h00 : lk_lcnt + 5'h01;
      if (lk_lcnt == 5'h00) begin
        lk_out_reg <= tgt_aligned[31];
        lk_tx_sh <= tgt_aligned << 1;
      end else begin
        lk_out_reg <= lk_tx_sh[31];
        lk_tx_sh <= lk_tx_sh << 1;
      end
    end
  end

  always_ff @(posedge lk_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lk_ack_tgl <= 1'b0;
    end else if (!i_cs_n && lk_lcnt == 5'h00) begin
      lk_ack_tgl <= ~lk_ack_tgl;
    end
  end

  always_ff @(negedge lk_clk or posedge i_cs_n) begin
    if (i_cs_n) begin
      lk_tcnt <= 5'h00;
      lk_rx_sh <= 32'h00000000;
    end else begin
      lk_rx_sh <= lk_rx_next;
      lk_tcnt <= (lk_tcnt == len) ? 5'h00 : lk_tcnt + 5'h01;
    end
  end

  always_ff @(negedge lk_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lk_done_tgl <= 1'b0;
      lk_rx_word <= 32'h00000000;
    end else if (!i_cs_n && lk_tcnt == len) begin
      lk_done_tgl <= ~lk_done_tgl;
      lk_rx_word <= lk_rx_next & (WORD_ONES >> (LEN_TOP - len));
    end
  end

  generate
    if (P_RESTRICTED) begin : g_restricted_lane1
      assign o_miso = io1_reg;
      assign o_miso_oe = io1_oe_reg;
    end else begin : g_target_out
      assign o_miso = lk_out_reg;
      assign o_miso_oe = lk_oe_reg;
    end
  endgenerate

  // ==========================================
  // Target crossing into system domain
  logic done_s1, done_s2, done_s3, ack_s1, ack_s2, ack_s3, tgt_have_reg;
  wire done_evt = done_s2 ^ done_s3;
  wire ack_evt = ack_s2 ^ ack_s3;
  wire tgt_pop = target_eff & i_enable & !tgt_have_reg & tx_ne;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      {done_s1, done_s2, done_s3, ack_s1, ack_s2, ack_s3} <= 6'h00;
      tgt_have_reg <= 1'b0;
      tgt_word_reg <= 32'h00000000;
    end else begin
      {done_s1, done_s2, done_s3} <= {lk_done_tgl, done_s1, done_s2};
      {ack_s1, ack_s2, ack_s3} <= {lk_ack_tgl, ack_s1, ack_s2};
      if (tgt_pop) begin
        tgt_have_reg <= 1'b1;
        tgt_word_reg <= tx_head;
      end else if (ack_evt) begin
        tgt_have_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // independent transmit and receive FIFOs
  spi_fifo u_tx_fifo (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_push(i_tx_valid),
    .i_wdata(i_tx_data),
    .i_pop(ini_pop | tgt_pop),
    .o_not_full(o_tx_ready),
    .o_not_empty(tx_ne),
    .o_head(tx_head)
  );

  spi_fifo u_rx_fifo (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_push(ini_push | (done_evt & target_eff)),
    .i_wdata(target_eff ? lk_rx_word : acc_next),
    .i_pop(i_rx_ready),
    .o_not_full(rx_nf),
    .o_not_empty(o_rx_valid),
    .o_head(o_rx_data)
  );
endmodule
`default_nettype wire

// file: spi_ctl_pkg.sv
// Purpose: Shared constants and types for the serial initiator/target controller
// Assumes: 40 MHz system clock; link clock from the far initiator in target role
// Notes: Mode n carries clock polarity in bit 1 and clock phase in bit 0
`default_nettype none
package spi_ctl_pkg;
  // ==========================================
  // Data path
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW = 2;
  // ==========================================
  // Packet lengths (programmed value is bits minus one)
  localparam logic [4:0] LEN_MIN = 5'h03;
  localparam logic [4:0] LEN_PACK4 = 5'h03;
  localparam logic [4:0] LEN_PACK8 = 5'h07;
  localparam logic [4:0] LEN_PACK16 = 5'h0F;
  localparam logic [4:0] LEN_TOP = 5'h1F;
  localparam logic [31:0] WORD_ONES = 32'hFFFFFFFF;
  // ==========================================
  // Mode fields and chip selects
  localparam int MODE_CPOL = 1;
  localparam int MODE_CPHA = 0;
  localparam logic [1:0] MODE_RESTRICTED = 2'h0;
  localparam logic [1:0] CS_ALL_IDLE = 2'h3;
  localparam logic [1:0] CS_SEL0 = 2'h2;
  localparam logic [1:0] CS_SEL1 = 2'h1;
  // ==========================================
  // Timing: half serial clock period in system cycles, least value
  localparam logic [7:0] DIV_MIN = 8'h03;
  // ==========================================
  // Initiator engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b10,
    ST_TAIL = 2'b11
  } eng_state_t;
endpackage
`default_nettype wire

// file: spi_ctl_props.sv
// Purpose: Port-level checks for the serial controller
// Assumes: Initiator tests use select 0; config changes only while idle
// Notes: Bound to every spi_ctl instance
`default_nettype none
module spi_ctl_props
  import spi_ctl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_target_mode,
  input wire logic [1:0] i_mode,
  input wire logic i_cs_sw_mode,
  input wire logic i_cs_sw_assert,
  input wire logic i_cs_sel,
  input wire logic i_cs_n,
  input wire logic i_rx_ready,
  input wire logic [DATA_W-1:0] o_rx_data,
  input wire logic o_rx_valid,
  input wire logic o_busy,
  input wire logic o_sck,
  input wire logic o_sck_oe,
  input wire logic [1:0] o_cs_n,
  input wire logic o_cs_oe,
  input wire logic o_mosi,
  input wire logic o_miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ==========================================
  // Sequences
  sequence sck_quiet2;
    (o_sck == i_mode[MODE_CPOL]) [*2];
  endsequence
  // ==========================================
  // Assertions
  rst_idle_a: assert property (disable iff (1'b0)
    i_sys_rst |=> o_cs_n == CS_ALL_IDLE && !o_rx_valid && !o_sck_oe && !o_busy)
    else $error("outputs not idle after reset");
  sck_idle_a: assert property (
    !o_busy && o_sck_oe && $stable(i_mode) |-> o_sck == i_mode[MODE_CPOL])
    else $error("clock not at idle level");
  sck_lead_a: assert property ($fell(o_cs_n[0]) && !i_target_mode |-> sck_quiet2)
    else $error("clock moved right after select");
  launch_edge_a: assert property (
    !i_target_mode && !i_cs_sw_mode && !o_cs_n[0] && $past(o_cs_n[0]) == 1'b0
    && $changed(o_mosi) |-> $changed(o_sck) && o_sck == (i_mode[1] ^ i_mode[0]))
    else $error("data changed off the launch edge");
  cs_onehot_a: assert property (o_cs_oe |-> o_cs_n != 2'h0)
    else $error("both selects low");
  sw_cs_a: assert property (
    i_cs_sw_mode && !i_cs_sel && o_cs_oe ##1 i_cs_sw_mode && !i_cs_sel
    |-> o_cs_n[0] == !$past(i_cs_sw_assert))
    else $error("software select not followed");
  miso_oe_a: assert property (i_target_mode && o_miso_oe |-> !i_cs_n)
    else $error("target drives while deselected");
  rx_hold_a: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
    else $error("receive word lost");
endmodule
bind spi_ctl spi_ctl_props u_props (.i_sys_clk, .i_sys_rst, .i_target_mode, .i_mode,
  .i_cs_sw_mode, .i_cs_sw_assert, .i_cs_sel, .i_cs_n, .i_rx_ready, .o_rx_data, .o_rx_valid,
  .o_busy, .o_sck, .o_sck_oe, .o_cs_n, .o_cs_oe, .o_mosi, .o_miso_oe);
`default_nettype wire

// file: spi_periph.sv
// Purpose: Behavioural serial peripheral on select 0
// Assumes: Eight-bit reply reloaded at each select
// Notes: Captured bits accumulate across frames
`default_nettype none
module spi_periph (
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic [1:0] i_mode,
  input wire logic [7:0] i_reply,
  output logic o_miso,
  output logic [31:0] o_got
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh = 8'h00;
  logic fresh = 1'b0;
  initial begin
    o_miso = 1'b0;
    o_got = 32'h00000000;
  end
  always @(negedge i_cs_n) begin
    sh = i_reply;
    fresh = i_mode[0];
    if (!i_mode[0]) o_miso = sh[7];
  end
  // released line shows no stale bit
  always @(posedge i_cs_n) o_miso = (o_miso !== 1'b1);
  // capture one edge, launch the other
  always @(i_sck) begin
    if (!i_cs_n && i_sck == ~(i_mode[1] ^ i_mode[0])) begin
      o_got = {o_got[30:0], i_mosi};
    end else if (!i_cs_n) begin
      if (fresh) fresh = 1'b0;
      else sh = sh << 1;
      o_miso = sh[7];
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench for the serial controller
// Assumes: Partner on select 0; bench acts as far initiator in target role
// Notes: Link clock runs only inside target frames
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import spi_ctl_pkg::*;
  logic i_sys_clk = 1'b0, i_sys_rst = 1'b0, i_link_sck = 1'b1, i_enable = 1'b0;
  logic i_target_mode = 1'b0, i_packed = 1'b0, i_cs_sw_mode = 1'b0, i_cs_sw_assert = 1'b0;
  logic i_cs_sel = 1'b0, i_tx_valid = 1'b0, i_rx_ready = 1'b0, i_cs_n = 1'b0, i_mosi = 1'b0;
  logic [1:0] i_mode = 2'h0;
  logic [4:0] i_bit_len = 5'h07;
  logic [7:0] i_clk_div = 8'h03, reply = 8'h00, seen, tv;
  logic [31:0] i_tx_data = 32'h00000000, got;
  logic o_tx_ready, o_rx_valid, o_busy, o_sck, o_sck_oe, o_cs_oe, o_mosi, o_mosi_oe;
  logic o_miso, o_miso_oe, i_miso;
  logic [1:0] o_cs_n;
  logic [31:0] o_rx_data;
  int miscompares = 0, total_checks = 0, m, k;
  always #12.5 i_sys_clk = ~i_sys_clk;
  spi_ctl #(.P_RESTRICTED(1'b0)) u_spi_ctl (.i_sys_clk, .i_sys_rst, .i_link_sck, .i_enable,
    .i_target_mode, .i_mode, .i_bit_len, .i_packed, .i_cs_sw_mode, .i_cs_sw_assert, .i_cs_sel,
    .i_clk_div, .i_dual(1'b0), .i_hd_rx(1'b0), .i_tx_data, .i_tx_valid, .o_tx_ready,
    .o_rx_data, .o_rx_valid, .i_rx_ready, .o_busy, .o_sck, .o_sck_oe, .o_cs_n, .o_cs_oe,
    .i_cs_n, .o_mosi, .o_mosi_oe, .i_mosi, .o_miso, .o_miso_oe, .i_miso);
  spi_periph u_spi_periph (.i_sck(o_sck), .i_cs_n(o_cs_n[0]), .i_mosi(o_mosi),
    .i_mode(i_mode), .i_reply(reply), .o_miso(i_miso), .o_got(got));
  // ==========================================
  // Tasks
  task tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task check(input logic [31:0] s, input logic [31:0] e, input string n);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task push(input logic [31:0] d);
    i_tx_data = d;
    i_tx_valid = 1'b1;
    for (k = 0; k < 50 && o_tx_ready !== 1'b1; k++) tick(1);
    check(o_tx_ready, 32'h1, "tx_ready");
    if (o_tx_ready !== 1'b1) end_sim();
    tick(1);
    i_tx_valid = 1'b0;
  endtask
  task pop(input logic [31:0] e, input string n);
    for (k = 0; k < 3000 && o_rx_valid !== 1'b1; k++) tick(1);
    check(o_rx_valid, 32'h1, "rx_valid");
    if (o_rx_valid !== 1'b1) end_sim();
    check(o_rx_data, e, n);
    i_rx_ready = 1'b1;
    tick(1);
    i_rx_ready = 1'b0;
  endtask
  task end_sim();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial begin
    #1;
    // Rising edges clear the link-side toggles and counters
    i_sys_rst = 1'b1;
    i_cs_n = 1'b1;
    tick(20);
    i_sys_rst = 1'b0;
    i_enable = 1'b1;
    for (m = 0; m < 4; m++) begin
      i_mode = 2'(m);
      reply = 8'h3C ^ 8'(m);
      tick(4);
      check(o_sck, {31'h0, i_mode[1]}, "sck_idle");
      check(o_mosi_oe, 32'h1, "mosi_oe");
      push({24'h000000, 8'h5A ^ 8'(m)});
      pop({24'h000000, reply}, "rx_mode");
      check(got[7:0], 8'h5A ^ 8'(m), "tx_mode");
    end
    i_bit_len = 5'h03;
    i_packed = 1'b1;
    reply = 8'h9F;
    tick(2);
    push(32'h76543210);
    pop({8{4'h9}}, "rx_packed");
    check(got, 32'h01234567, "tx_packed");
    i_packed = 1'b0;
    i_cs_sw_mode = 1'b1;
    i_cs_sw_assert = 1'b1;
    tick(3);
    check(o_cs_n, 2'h2, "cs_sw0");
    i_cs_sel = 1'b1;
    tick(3);
    check(o_cs_n, 2'h1, "cs_sw1");
    i_cs_sw_assert = 1'b0;
    tick(3);
    check(o_cs_n, 2'h3, "cs_sw_off");
    i_cs_sw_mode = 1'b0;
    i_cs_sel = 1'b0;
    i_target_mode = 1'b1;
    i_bit_len = 5'h07;
    tv = 8'hA7;
    push(32'h000000C6);
    tick(10);
    i_cs_n = 1'b0;
    tick(8);
    check(o_busy, 32'h1, "busy_target");
    check(o_mosi_oe, 32'h0, "mosi_oe_target");
    check(o_sck_oe, 32'h0, "sck_oe_target");
    #7;
    for (k = 7; k >= 0; k--) begin
      i_link_sck = 1'b0;
      i_mosi = tv[k];
      #62.5;
      i_link_sck = 1'b1;
      seen = {seen[6:0], o_miso};
      #62.5;
    end
    check(o_miso_oe, 32'h1, "miso_oe_on");
    i_cs_n = 1'b1;
    i_mosi = ~i_mosi;
    pop({24'h000000, tv}, "rx_target");
    check(seen, 8'hC6, "tx_target");
    tick(5);
    check(o_miso_oe, 32'h0, "miso_oe_off");
    end_sim();
  end
endmodule
`default_nettype wire
